// >>> pkg/ems_map.svh
`ifndef EMS_MAP_SVH
`define EMS_MAP_SVH

// Oscillator periods per machine cycle
`define EMS_MC_CLOCKS         12
// Machine cycles the reset pin must stay high
`define EMS_RST_QUAL_MC       2
// Oscillator periods the internal reset holds after a watchdog overflow
`define EMS_WDT_RESET_CLOCKS  24

// Phase counter width and last phase of a machine cycle
`define EMS_PHASE_W           4
`define EMS_PHASE_LAST        4'hB

// Address-latch strobe high phases (two per machine cycle)
`define EMS_ALE1_FIRST        4'h1
`define EMS_ALE1_LAST         4'h2
`define EMS_ALE2_FIRST        4'h7
`define EMS_ALE2_LAST         4'h8

// Program-fetch strobe low phases (two per machine cycle)
`define EMS_PSEN1_FIRST       4'h3
`define EMS_PSEN1_LAST        4'h5
`define EMS_PSEN2_FIRST       4'h9
`define EMS_PSEN2_LAST        4'hB

// Highest address of internal program memory
`define EMS_INT_CODE_TOP      16'h7FFF

// Reset values of the strobes
`define EMS_ALE_RESET         1'b0
`define EMS_PROGRAM_FETCH_STROBE_N_RESET      1'b1

`endif

// >>> pkg/ems_pkg.sv
package ems_pkg;

    // Strobes that leave the block towards the external memory
    typedef struct packed {
        logic ale;
        logic program_fetch_strobe_n;
    } ems_strobe_t;

    // Reset pin drive: level and output enable
    typedef struct packed {
        logic out;
        logic oe;
    } ems_rst_drive_t;

    // Reset source state
    typedef enum logic [1:0] {
        EMS_RUN,
        EMS_PIN_RESET,
        EMS_WDT_RESET
    } ems_rst_state_t;

endpackage

// >>> rtl/ems_mem_strobe.sv
`timescale 1ns/1ps
`include "ems_map.svh"

// Notes on behaviour
// - Reset pin high for two machine cycles with oscillator running resets device.
// - On watchdog overflow the reset pin is driven high while internal reset lasts.
// - Address-latch strobe normally runs at one sixth of the oscillator rate.
// - Address-latch strobe lets external logic latch the low address byte.
// - Each external data access drops exactly one address-latch strobe pulse.
// - Program-fetch strobe is the read enable of external program memory.
// - Executing externally, program-fetch strobe asserts twice each machine cycle.
// - Each external data access drops two program-fetch strobe assertions.
// - Program-fetch strobe stays inactive for internal program fetches.
// - Fetch select low during reset: all code 0000H-FFFFH fetched externally.
// - Fetch select high during reset: internal code, external above 7FFFH.
// - Fetch select is sampled only during reset, ignored afterwards.

module ems_mem_strobe #(
    parameter int MC_CLOCKS        = `EMS_MC_CLOCKS,
    parameter int RST_QUAL_MC      = `EMS_RST_QUAL_MC,
    parameter int WDT_RESET_CLOCKS = `EMS_WDT_RESET_CLOCKS
) (
    // Clock and system reset
    input  wire logic                 CLK,
    input  wire logic                 SYS_RST,
    // Reset pin
    input  wire logic                 RST_PIN_IN,
    output ems_pkg::ems_rst_drive_t   RST_PIN_DRIVE,
    // Watchdog
    input  wire logic                 WDT_OVERFLOW,
    // Fetch select pin, low selects external code
    input  wire logic                 EXTERNAL_FETCH_SELECT_N,
    // Core side
    input  wire logic [15:0]          PROGRAM_COUNTER,
    input  wire logic                 DATA_ACCESS_REQ,
    output logic                      INTERNAL_RESET,
    output logic                      MACHINE_CYCLE_START,
    output logic                      FETCH_EXTERNAL,
    output logic                      DATA_CYCLE,
    // External memory strobes
    output ems_pkg::ems_strobe_t      STROBES
);

    localparam int QUAL_CLOCKS = RST_QUAL_MC * MC_CLOCKS;
    localparam int QCNT_W      = $clog2(QUAL_CLOCKS + 1);
    localparam int WCNT_W      = $clog2(WDT_RESET_CLOCKS + 1);

    // True when the phase lies in the window [first, last]
    function automatic logic in_window(
        input logic [`EMS_PHASE_W-1:0] ph,
        input logic [`EMS_PHASE_W-1:0] first,
        input logic [`EMS_PHASE_W-1:0] last
    );
        in_window = (ph >= first) && (ph <= last);
    endfunction

    // Code address goes to external memory
    function automatic logic code_is_external(
        input logic        ext_sel,
        input logic [15:0] pc
    );
        code_is_external = ext_sel || (pc > `EMS_INT_CODE_TOP);
    endfunction

    // Pin synchronisers
    logic                        rst_pin_meta_reg;
    logic                        rst_pin_sync_reg;
    logic                        sel_meta_reg;
    logic                        sel_sync_reg;

    // Reset control
    ems_pkg::ems_rst_state_t     rst_state_reg;
    logic [QCNT_W-1:0]           qual_cnt_reg;
    logic [WCNT_W-1:0]           wdt_cnt_reg;
    logic                        in_reset_reg;
    logic                        rst_drive_reg;

    // Boot select and machine timing
    logic                        ext_sel_reg;
    logic [`EMS_PHASE_W-1:0]     phase_reg;
    logic                        mc_start_reg;
    logic                        data_cycle_reg;
    logic                        fetch_ext_reg;
    logic                        ale_reg;
    logic                        program_fetch_strobe_n_reg;
    logic                        ale_next;
    logic                        program_fetch_strobe_n_next;
    logic                        last_phase;

    // Pins from outside pass two flip-flops first
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            rst_pin_meta_reg <= 1'b0;
            rst_pin_sync_reg <= 1'b0;
        end else begin
            rst_pin_meta_reg <= RST_PIN_IN;
            rst_pin_sync_reg <= rst_pin_meta_reg;
        end
    end

    // Fetch select tracks the pin even in system reset so it can be caught there
    always_ff @(posedge CLK) begin
        sel_meta_reg <= EXTERNAL_FETCH_SELECT_N;
        sel_sync_reg <= sel_meta_reg;
    end

    // Qualify the reset pin; our own drive during a watchdog reset is not counted
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            qual_cnt_reg <= '0;
        end else if (!rst_pin_sync_reg || rst_drive_reg) begin
            qual_cnt_reg <= '0;
        end else if (qual_cnt_reg != QCNT_W'(QUAL_CLOCKS)) begin
            qual_cnt_reg <= qual_cnt_reg + QCNT_W'(1);
        end
    end

    // Reset source state machine
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            rst_state_reg <= ems_pkg::EMS_RUN;
            wdt_cnt_reg   <= '0;
        end else begin
            case (rst_state_reg)
                ems_pkg::EMS_RUN: begin
                    if (qual_cnt_reg == QCNT_W'(QUAL_CLOCKS)) begin
                        rst_state_reg <= ems_pkg::EMS_PIN_RESET;
                    end else if (WDT_OVERFLOW) begin
                        rst_state_reg <= ems_pkg::EMS_WDT_RESET;
                        wdt_cnt_reg   <= WCNT_W'(WDT_RESET_CLOCKS - 1);
                    end
                end
                ems_pkg::EMS_PIN_RESET: begin
                    if (!rst_pin_sync_reg) begin
                        rst_state_reg <= ems_pkg::EMS_RUN;
                    end
                end
                ems_pkg::EMS_WDT_RESET: begin
                    if (wdt_cnt_reg == '0) begin
                        rst_state_reg <= ems_pkg::EMS_RUN;
                    end else begin
                        wdt_cnt_reg <= wdt_cnt_reg - WCNT_W'(1);
                    end
                end
                default: begin
                    rst_state_reg <= ems_pkg::EMS_RUN;
                end
            endcase
        end
    end

    // Internal reset and reset pin drive
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            in_reset_reg  <= 1'b1;
            rst_drive_reg <= 1'b0;
        end else begin
            in_reset_reg  <= (rst_state_reg != ems_pkg::EMS_RUN);
            rst_drive_reg <= (rst_state_reg == ems_pkg::EMS_WDT_RESET);
        end
    end

    // Boot select: caught only while reset stands, held afterwards
    always_ff @(posedge CLK) begin
        if (SYS_RST || in_reset_reg) begin
            ext_sel_reg <= !sel_sync_reg;
        end
    end

    // Machine cycle phase counter, twelve oscillator periods
    assign last_phase = (phase_reg == `EMS_PHASE_LAST);

    always_ff @(posedge CLK) begin
        if (SYS_RST || in_reset_reg) begin
            phase_reg    <= `EMS_PHASE_LAST;
            mc_start_reg <= 1'b0;
        end else begin
            phase_reg    <= last_phase ? '0 : phase_reg + `EMS_PHASE_W'(1);
            mc_start_reg <= last_phase;
        end
    end

    // Per machine cycle: data access and code source decided at its start
    always_ff @(posedge CLK) begin
        if (SYS_RST || in_reset_reg) begin
            data_cycle_reg <= 1'b0;
            fetch_ext_reg  <= 1'b0;
        end else if (last_phase) begin
            data_cycle_reg <= DATA_ACCESS_REQ;
            fetch_ext_reg  <= code_is_external(ext_sel_reg, PROGRAM_COUNTER);
        end
    end

    // Strobe patterns for the current phase
    always_comb begin
        ale_next    = in_window(phase_reg, `EMS_ALE1_FIRST, `EMS_ALE1_LAST);
        program_fetch_strobe_n_next = 1'b1;
        if (!data_cycle_reg) begin
            ale_next = ale_next
                       || in_window(phase_reg, `EMS_ALE2_FIRST, `EMS_ALE2_LAST);
        end
        if (fetch_ext_reg && !data_cycle_reg) begin
            program_fetch_strobe_n_next = !(in_window(phase_reg, `EMS_PSEN1_FIRST, `EMS_PSEN1_LAST)
                         || in_window(phase_reg, `EMS_PSEN2_FIRST, `EMS_PSEN2_LAST));
        end
    end

    // Strobes leave from flip-flops; data cycles drop one latch pulse, two fetches
    always_ff @(posedge CLK) begin
        if (SYS_RST || in_reset_reg) begin
            ale_reg    <= `EMS_ALE_RESET;
            program_fetch_strobe_n_reg <= `EMS_PROGRAM_FETCH_STROBE_N_RESET;
        end else begin
            ale_reg    <= ale_next;
            program_fetch_strobe_n_reg <= program_fetch_strobe_n_next;
        end
    end

    assign STROBES       = '{ale: ale_reg, program_fetch_strobe_n: program_fetch_strobe_n_reg};
    assign RST_PIN_DRIVE = '{out: rst_drive_reg, oe: rst_drive_reg};
    assign INTERNAL_RESET                 = in_reset_reg;
    assign MACHINE_CYCLE_START            = mc_start_reg;
    assign FETCH_EXTERNAL                 = fetch_ext_reg;
    assign DATA_CYCLE                     = data_cycle_reg;

endmodule

// >>> verif/ems_mem_strobe_chk.sv
`timescale 1ns/1ps
module ems_mem_strobe_chk #(
    parameter int MC_CLOCKS        = 12,
    parameter int RST_QUAL_MC      = 2,
    parameter int WDT_RESET_CLOCKS = 24
) (
    // Clock and reset
    input wire logic                    CLK,
    input wire logic                    SYS_RST,
    // Pins and watchdog
    input wire logic                    RST_PIN_IN,
    input wire ems_pkg::ems_rst_drive_t RST_PIN_DRIVE,
    input wire logic                    WDT_OVERFLOW,
    input wire logic                    EXTERNAL_FETCH_SELECT_N,
    // Core side
    input wire logic [15:0]             PROGRAM_COUNTER,
    input wire logic                    DATA_ACCESS_REQ,
    input wire logic                    INTERNAL_RESET,
    input wire logic                    MACHINE_CYCLE_START,
    input wire logic                    FETCH_EXTERNAL,
    input wire logic                    DATA_CYCLE,
    input wire ems_pkg::ems_strobe_t    STROBES
);
    logic       sel_reg;
    logic       armed_reg;
    logic [7:0] hi_reg;
    logic [7:0] oe_reg;
    always_ff @(posedge CLK) begin
        if (SYS_RST || INTERNAL_RESET) begin
            sel_reg <= EXTERNAL_FETCH_SELECT_N;
        end
    end
    // Decision checks start one machine cycle after reset
    always_ff @(posedge CLK) begin
        armed_reg <= !(SYS_RST || INTERNAL_RESET) && (armed_reg || MACHINE_CYCLE_START);
    end
    always_ff @(posedge CLK) begin
        hi_reg <= RST_PIN_IN ? hi_reg + {7'h0, hi_reg != 8'hFF} : 8'h00;
    end
    always_ff @(posedge CLK) begin
        oe_reg <= RST_PIN_DRIVE.oe ? oe_reg + 8'h01 : 8'h00;
    end
    default clocking cb @(posedge CLK); endclocking
    default disable iff (SYS_RST || INTERNAL_RESET);
    chk_mc_period:
    assert property (MACHINE_CYCLE_START |-> ##1 !MACHINE_CYCLE_START[*8]
        ##1 !MACHINE_CYCLE_START[*3] ##1 MACHINE_CYCLE_START) else $error("cycle length wrong");
    chk_ale_pattern:
    assert property (MACHINE_CYCLE_START |-> !STROBES.ale[*2] ##1 STROBES.ale[*2]
        ##1 !STROBES.ale[*4] ##1 (STROBES.ale == !DATA_CYCLE)[*2] ##1 !STROBES.ale)
        else $error("latch strobe pattern wrong");
    chk_fetch_twice:
    assert property (MACHINE_CYCLE_START && FETCH_EXTERNAL && !DATA_CYCLE |->
        ##4 !STROBES.program_fetch_strobe_n[*3] ##1 STROBES.program_fetch_strobe_n[*3]
        ##1 !STROBES.program_fetch_strobe_n[*3]) else $error("fetch strobe pattern wrong");
    chk_fetch_quiet:
    assert property (MACHINE_CYCLE_START && !(FETCH_EXTERNAL && !DATA_CYCLE) |->
        ##1 STROBES.program_fetch_strobe_n[*8] ##1 STROBES.program_fetch_strobe_n[*4])
        else $error("fetch strobe not idle");
    chk_boot_ext:
    assert property (MACHINE_CYCLE_START && armed_reg && !sel_reg |-> FETCH_EXTERNAL)
        else $error("external boot not kept");
    chk_pc_select:
    assert property (MACHINE_CYCLE_START && armed_reg && sel_reg |->
        FETCH_EXTERNAL == ($past(PROGRAM_COUNTER) > 16'h7FFF)) else $error("code select wrong");
    chk_data_cycle:
    assert property (MACHINE_CYCLE_START && armed_reg |-> DATA_CYCLE == $past(DATA_ACCESS_REQ))
        else $error("data cycle decision wrong");
    chk_wdt_drive:
    assert property (disable iff (SYS_RST) WDT_OVERFLOW && !INTERNAL_RESET && !RST_PIN_IN
        |-> ##2 (INTERNAL_RESET && RST_PIN_DRIVE == 2'b11)) else $error("pin not driven");
    chk_wdt_length:
    assert property (disable iff (SYS_RST) $fell(RST_PIN_DRIVE.oe) |->
        oe_reg == 8'(WDT_RESET_CLOCKS) && !INTERNAL_RESET) else $error("drive length wrong");
    chk_pin_reset:
    assert property (disable iff (SYS_RST) hi_reg == 8'(MC_CLOCKS * RST_QUAL_MC + 6)
        |-> INTERNAL_RESET) else $error("pin reset not taken");
endmodule

// >>> verif/ems_ext_mem.sv
`timescale 1ns/1ps
// External code memory with address latch, reduced to counting its strobes
module ems_ext_mem (
    // Strobes from the block
    input  wire ems_pkg::ems_strobe_t strobes,
    // Pulses seen so far
    output int                        latch_cnt,
    output int                        read_cnt
);
    int n_latch = 0;
    int n_read  = 0;
    always @(posedge strobes.ale) n_latch++;
    always @(negedge strobes.program_fetch_strobe_n) n_read++;
    assign latch_cnt = n_latch;
    assign read_cnt  = n_read;
endmodule

// >>> verif/tb.sv
`timescale 1ns/1ps
module tb;
    logic clk = 0, sys_rst = 1, ext_rst = 0, wdt = 0, sel_n = 0, dar = 0;
    logic [15:0] pc = 16'h0100;
    logic irst, mcs, fext, dcyc;
    ems_pkg::ems_rst_drive_t drive;
    ems_pkg::ems_strobe_t    strobes;
    int latch_cnt, read_cnt, da, dr;
    int n_errors = 0;
    int tests_run = 0;
    wire rst_wire = drive.oe ? drive.out : ext_rst;
    always #2.5 clk = ~clk;
    ems_mem_strobe #(.WDT_RESET_CLOCKS(4)) dut (.CLK(clk), .SYS_RST(sys_rst),
        .RST_PIN_IN(rst_wire), .RST_PIN_DRIVE(drive), .WDT_OVERFLOW(wdt),
        .EXTERNAL_FETCH_SELECT_N(sel_n), .PROGRAM_COUNTER(pc), .DATA_ACCESS_REQ(dar),
        .INTERNAL_RESET(irst), .MACHINE_CYCLE_START(mcs), .FETCH_EXTERNAL(fext),
        .DATA_CYCLE(dcyc), .STROBES(strobes));
    ems_ext_mem mem (.strobes(strobes), .latch_cnt(latch_cnt), .read_cnt(read_cnt));
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_errors++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic summarize;
        $display("checks=%0d errors=%0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    task automatic wait_mcs;
        int i;
        @(negedge clk);
        for (i = 0; i < 40 && mcs !== 1'b1; i++) @(negedge clk);
        if (mcs !== 1'b1) begin
            n_errors++;
            summarize();
        end
    endtask
    // Pulses over the machine cycle after the next one
    task automatic measure;
        int a0, r0;
        wait_mcs();
        wait_mcs();
        a0 = latch_cnt;
        r0 = read_cnt;
        wait_mcs();
        da = latch_cnt - a0;
        dr = read_cnt - r0;
    endtask
    task automatic do_reset(input logic sel);
        @(posedge clk);
        sel_n   <= sel;
        sys_rst <= 1'b1;
        repeat (10) @(posedge clk);
        sys_rst <= 1'b0;
    endtask
    task automatic t_ext_boot;
        do_reset(1'b0);
        measure();
        check(16'(da), 16'h0002);
        check(16'(dr), 16'h0002);
        @(posedge clk) sel_n <= 1'b1;
        measure();
        check(16'(dr), 16'h0002);
    endtask
    task automatic t_data;
        @(posedge clk) dar <= 1'b1;
        measure();
        check(16'(da), 16'h0001);
        check(16'(dr), 16'h0000);
        wait_mcs();
        check({15'h0, dcyc}, 16'h0001);
        @(posedge clk) dar <= 1'b0;
    endtask
    task automatic t_internal;
        do_reset(1'b1);
        measure();
        check(16'(da), 16'h0002);
        check(16'(dr), 16'h0000);
        @(posedge clk) pc <= 16'h8000;
        measure();
        check(16'(dr), 16'h0002);
        @(posedge clk) pc <= 16'h7FFF;
        measure();
        check(16'(dr), 16'h0000);
    endtask
    task automatic t_pin;
        @(posedge clk) ext_rst <= 1'b1;
        repeat (12) @(posedge clk);
        ext_rst <= 1'b0;
        repeat (8) @(negedge clk);
        check({15'h0, irst}, 16'h0000);
        @(posedge clk) ext_rst <= 1'b1;
        repeat (40) @(negedge clk);
        check({15'h0, irst}, 16'h0001);
        @(posedge clk) ext_rst <= 1'b0;
        repeat (8) @(negedge clk);
        check({15'h0, irst}, 16'h0000);
    endtask
    task automatic t_wdt;
        @(posedge clk) wdt <= 1'b1;
        @(posedge clk) wdt <= 1'b0;
        repeat (2) @(negedge clk);
        check({14'h0, drive}, 16'h0003);
        check({15'h0, irst}, 16'h0001);
        repeat (8) @(negedge clk);
        check({14'h0, drive.oe, irst}, 16'h0000);
        measure();
        check(16'(da), 16'h0002);
    endtask
    initial begin
        t_ext_boot();
        t_data();
        t_internal();
        t_pin();
        t_wdt();
        summarize();
    end
endmodule
bind ems_mem_strobe ems_mem_strobe_chk #(.MC_CLOCKS(MC_CLOCKS), .RST_QUAL_MC(RST_QUAL_MC),
    .WDT_RESET_CLOCKS(WDT_RESET_CLOCKS)) u_chk (.*);
